// >>> hw/sfd_cfg.svh
// offsets, flag masks, kind codes and counts of the submessage flag decoder
`ifndef SFD_CFG_SVH
`define SFD_CFG_SVH
// submessage kind codes
`define SFD_K_HB 8'h07
`define SFD_K_GAP 8'h08
`define SFD_K_IDST 8'h0e
`define SFD_K_HBFR 8'h13
`define SFD_K_DATA 8'h15
`define SFD_K_FRAG 8'h16
// flag masks
`define SFD_F_E 8'h01
`define SFD_F_Q 8'h02
`define SFD_F_DD 8'h04
`define SFD_F_DK 8'h08
`define SFD_F_DN 8'h10
`define SFD_F_FK 8'h04
`define SFD_F_FN 8'h08
`define SFD_F_HF 8'h02
`define SFD_F_HL 8'h04
// flags defined per kind, everything else is unused
`define SFD_M_DATA 8'h1f
`define SFD_M_FRAG 8'h0f
`define SFD_M_HB 8'h07
`define SFD_M_EONLY 8'h01
// transmitted extra flags
`define SFD_EXTRA_TX 16'h0000
// register byte offsets
`define SFD_A_CTRL 5'h00
`define SFD_A_STAT 5'h04
`define SFD_A_HBCNT 5'h08
`define SFD_A_TXCFG 5'h0c
`define SFD_A_TXGO 5'h10
`define SFD_A_ERRS 5'h14
// register fields and reset values
`define SFD_ST_ERR 16
`define SFD_CTRL_RST 1'b1
// heartbeat body: count field occupies octets 24..27
`define SFD_HB_CNT_FIRST 16'h0018
`define SFD_HB_CNT_LAST 16'h001b
`endif

// >>> hw/sfd_pkg.sv
// types and shared decode functions of the submessage flag decoder
package sfd_pkg;
  `include "sfd_cfg.svh"

  // parser states, one-hot
  typedef enum logic [10:0] {
    S_ID = 11'h001,
    S_FLG = 11'h002,
    S_LEN0 = 11'h004,
    S_LEN1 = 11'h008,
    S_EXT0 = 11'h010,
    S_EXT1 = 11'h020,
    S_OTQ0 = 11'h040,
    S_OTQ1 = 11'h080,
    S_SKIP = 11'h100,
    S_PAY = 11'h200,
    S_BODY = 11'h400
  } sfd_state_e;

  // flag bits that carry meaning for a given kind
  function automatic logic [7:0] sfd_kind_mask(input logic [7:0] kind);
    if (kind == `SFD_K_DATA)
      sfd_kind_mask = `SFD_M_DATA;
    else if (kind == `SFD_K_FRAG)
      sfd_kind_mask = `SFD_M_FRAG;
    else if (kind == `SFD_K_HB)
      sfd_kind_mask = `SFD_M_HB;
    else
      sfd_kind_mask = `SFD_M_EONLY;
  endfunction

  // join two octets of a 16-bit field in wire order
  function automatic logic [15:0] sfd_join16(input logic le, input logic [7:0] b0,
                                             input logic [7:0] b1);
    sfd_join16 = le ? {b1, b0} : {b0, b1};
  endfunction
endpackage

// >>> hw/sfd_flag_dec.sv
// combinational decode of the submessage header flags octet
`timescale 1ns/1ps
`default_nettype none
`include "sfd_cfg.svh"
module sfd_flag_dec
  import sfd_pkg::*;
(
  // header
  input wire logic [7:0] kind,
  input wire logic [7:0] flags,
  // decoded flags
  output logic little_e,
  output logic inl_qos,
  output logic has_data,
  output logic has_key,
  output logic non_std,
  output logic final_f,
  output logic live_f,
  output logic bad_combo
);
  // unused bits are dropped here, per kind
  wire logic [7:0] used = flags & sfd_kind_mask(kind);
  wire logic is_data = (kind == `SFD_K_DATA);
  wire logic is_frag = (kind == `SFD_K_FRAG);
  wire logic is_hb = (kind == `SFD_K_HB);

  assign little_e = |(flags & `SFD_F_E);
  assign inl_qos = (is_data | is_frag) & |(used & `SFD_F_Q);
  assign has_data = is_data & |(used & `SFD_F_DD);
  // data: key mask 0x08, frag: key mask 0x04
  assign has_key = is_data ? |(used & `SFD_F_DK) : (is_frag & |(used & `SFD_F_FK));
  assign non_std = is_data ? |(used & `SFD_F_DN) : (is_frag & |(used & `SFD_F_FN));
  assign final_f = is_hb & |(used & `SFD_F_HF);
  assign live_f = is_hb & |(used & `SFD_F_HL);
  assign bad_combo = has_data & has_key;
endmodule
`default_nettype wire

// >>> hw/sfd_hdr_enc.sv
// builds a clean submessage header word and the extra-flags word for sending
`timescale 1ns/1ps
`default_nettype none
`include "sfd_cfg.svh"
module sfd_hdr_enc
  import sfd_pkg::*;
(
  // requested header
  input wire logic [7:0] kind,
  input wire logic [7:0] flags_req,
  input wire logic [15:0] len,
  input wire logic [15:0] otq,
  // wire words, first octet in bits 31:24
  output logic [31:0] hdr,
  output logic [31:0] ext
);
  wire logic [7:0] masked = flags_req & sfd_kind_mask(kind);
  // never emit data and key together: key is dropped
  wire logic bad = (kind == `SFD_K_DATA) & |(masked & `SFD_F_DD) & |(masked & `SFD_F_DK);
  wire logic [7:0] clean = bad ? (masked & ~`SFD_F_DK) : masked;
  wire logic le = |(clean & `SFD_F_E);
  wire logic [15:0] len_w = le ? {len[7:0], len[15:8]} : len;
  wire logic [15:0] otq_w = le ? {otq[7:0], otq[15:8]} : otq;
  assign hdr = {kind, clean, len_w};
  // sixteen extra flag bits, all zero in this version
  assign ext = {`SFD_EXTRA_TX, otq_w};
endmodule
`default_nettype wire

// >>> hw/sfd_top.sv
// submessage flag decoder: receive parser, send header builder, register slave
//
// Contract
// - data plus key flags is invalid
// - data non-standard payload flag mask 0x10
// - sixteen extra flag bits follow header flags
// - send extra flags as all zero
// - inline qos offset counts from after field
// - without qos, offset points past it
// - receiver always skips by that offset
// - fragment inline qos flag mask 0x02
// - fragment key flag mask 0x04
// - fragment non-standard payload mask 0x08
// - gap and destination: endian flag only
// - heartbeat fragment: endian flag only
// - heartbeat final 0x02; clear asks reply
// - heartbeat liveliness 0x04 asks refresh
// - flag bit 0 selects byte order
// - unused flags: send zero, ignore received
// - data masks: qos 02, data 04, key 08
`timescale 1ns/1ps
`default_nettype none
`include "sfd_cfg.svh"
module sfd_top
  import sfd_pkg::*;
#(
  parameter int ERR_W = 16 // width of the error counter
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // received octet stream from the remote participant
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  // payload toward local reader
  output logic pl_valid,
  output logic [7:0] pl_data,
  output logic pl_key,
  // events toward local reader
  output logic err_pulse,
  output logic hb_reply,
  output logic hb_live,
  output logic [31:0] hb_count,
  // header words toward the send path
  output logic tx_valid,
  output logic [31:0] tx_hdr,
  output logic [31:0] tx_ext
);
  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (ERR_W < 1 || ERR_W > 32)
  begin : g_chk
    $error("ERR_W must be 1..32");
  end

  // ----------------------------------------
  // parser state
  // ----------------------------------------
  sfd_state_e st; // current parse state
  sfd_state_e next_st;
  logic [7:0] kind; // submessage kind
  logic [7:0] flags; // header flags octet
  logic [7:0] b0; // first octet of a 16-bit field
  logic [15:0] rem; // octets left in submessage
  logic unlim; // length zero: runs to end of message
  logic [15:0] pos; // body octet index
  logic [15:0] skip; // octets left to skip
  logic bad_r; // invalid flag combination seen
  logic ctrl_en; // receive enable
  logic err_st; // sticky error
  logic [ERR_W-1:0] err_cnt; // error counter
  logic [7:0] tx_kind; // send kind
  logic [7:0] tx_flags; // send flags request
  logic [15:0] tx_otq; // send inline qos offset
  logic ack; // bus answer cycle

  // decoder feeds on the live octet while the flags arrive
  wire logic [7:0] dec_flags = (st == S_FLG) ? rx_data : flags;
  wire logic d_le, d_qos, d_data, d_key, d_nsp, d_fin, d_live, d_bad;

  sfd_flag_dec u_dec (
    .kind(kind),
    .flags(dec_flags),
    .little_e(d_le),
    .inl_qos(d_qos),
    .has_data(d_data),
    .has_key(d_key),
    .non_std(d_nsp),
    .final_f(d_fin),
    .live_f(d_live),
    .bad_combo(d_bad)
  );

  // ----------------------------------------
  // receive decode wires
  // ----------------------------------------
  assign rx_ready = 1'b1; // no back-pressure
  wire logic fire = rx_valid & ctrl_en;
  wire logic [15:0] j16 = sfd_join16(d_le, b0, rx_data);
  wire logic in_body = (st == S_EXT0) | (st == S_EXT1) | (st == S_OTQ0) | (st == S_OTQ1)
                       | (st == S_SKIP) | (st == S_PAY) | (st == S_BODY);
  wire logic sm_end = rx_last | (in_body & ~unlim & (rem == 16'h0001));
  wire logic is_df = (kind == `SFD_K_DATA) | (kind == `SFD_K_FRAG);
  wire logic is_hb = (kind == `SFD_K_HB);
  wire logic hb_done = fire & (st == S_BODY) & is_hb & (pos == `SFD_HB_CNT_LAST);
  wire logic flg_err = fire & (st == S_FLG) & d_bad;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    if (fire)
    begin
      case (st)
        S_ID: next_st = S_FLG;
        S_FLG: next_st = S_LEN0;
        S_LEN0: next_st = S_LEN1;
        // gap, destination, heartbeat fragment and unknown kinds just drain
        S_LEN1: next_st = is_df ? S_EXT0 : S_BODY;
        S_EXT0: next_st = S_EXT1;
        S_EXT1: next_st = S_OTQ0;
        // an offset of zero means the next element starts here
        S_OTQ1: next_st = (j16 == 16'h0000) ? S_PAY : S_SKIP;
        S_SKIP: next_st = (skip == 16'h0001) ? S_PAY : S_SKIP;
        S_OTQ0: next_st = S_OTQ1;
        S_PAY: next_st = S_PAY;
        S_BODY: next_st = S_BODY;
        default: next_st = S_ID;
      endcase
      if (sm_end)
        next_st = S_ID;
    end
  end

  // ----------------------------------------
  // parser registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= S_ID;
    else
      st <= next_st;
  end

  // header capture and length tracking
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      kind <= 8'h00;
      flags <= 8'h00;
      b0 <= 8'h00;
      rem <= 16'h0000;
      unlim <= 1'b0;
      pos <= 16'h0000;
      skip <= 16'h0000;
      bad_r <= 1'b0;
    end
    else if (fire)
    begin
      if (st == S_ID)
        kind <= rx_data;
      if (st == S_FLG)
        flags <= rx_data;
      if (st == S_FLG)
        bad_r <= d_bad;
      if ((st == S_LEN0) | (st == S_OTQ0))
        b0 <= rx_data;
      if (st == S_LEN1)
      begin
        rem <= j16;
        unlim <= (j16 == 16'h0000);
        pos <= 16'h0000;
      end
      else if (in_body)
      begin
        rem <= rem - 16'h0001;
        pos <= pos + 16'h0001;
      end
      // skip past any header elements not understood
      if (st == S_OTQ1)
        skip <= j16;
      else if (st == S_SKIP)
        skip <= skip - 16'h0001;
    end
  end

  // heartbeat count assembled in the selected byte order
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      hb_count <= 32'h0000_0000;
    else if (fire & (st == S_BODY) & is_hb & (pos >= `SFD_HB_CNT_FIRST)
             & (pos <= `SFD_HB_CNT_LAST))
      hb_count <= d_le ? {rx_data, hb_count[31:8]} : {hb_count[23:0], rx_data};
  end

  // payload forwarding and event pulses
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pl_valid <= 1'b0;
      pl_data <= 8'h00;
      pl_key <= 1'b0;
      err_pulse <= 1'b0;
      hb_reply <= 1'b0;
      hb_live <= 1'b0;
    end
    else
    begin
      pl_valid <= fire & (st == S_PAY) & ~bad_r;
      pl_data <= rx_data;
      pl_key <= d_key;
      err_pulse <= flg_err;
      hb_reply <= hb_done & ~d_fin;
      hb_live <= hb_done & d_live;
    end
  end

  // ----------------------------------------
  // send header builder
  // ----------------------------------------
  wire logic [31:0] enc_hdr, enc_ext;

  sfd_hdr_enc u_enc (
    .kind(tx_kind),
    .flags_req(tx_flags),
    .len(avs_writedata[15:0]),
    .otq(tx_otq),
    .hdr(enc_hdr),
    .ext(enc_ext)
  );

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  wire logic req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  wire logic wr_do = avs_write & ack;
  wire logic wr_ctrl = wr_do & (avs_address == `SFD_A_CTRL);
  wire logic wr_stat = wr_do & (avs_address == `SFD_A_STAT);
  wire logic wr_txcfg = wr_do & (avs_address == `SFD_A_TXCFG);
  wire logic wr_txgo = wr_do & (avs_address == `SFD_A_TXGO);
  logic [31:0] rd_mux;

  // read selection, unmapped reads zero
  always_comb
  begin
    if (avs_address == `SFD_A_CTRL)
      rd_mux = {31'h0000_0000, ctrl_en};
    else if (avs_address == `SFD_A_STAT)
      rd_mux = {15'h0000, err_st, flags, kind};
    else if (avs_address == `SFD_A_HBCNT)
      rd_mux = hb_count;
    else if (avs_address == `SFD_A_TXCFG)
      rd_mux = {tx_otq, tx_flags, tx_kind};
    else if (avs_address == `SFD_A_ERRS)
      rd_mux = 32'(err_cnt);
    else
      rd_mux = 32'h0000_0000;
  end

  // answer one cycle after the request
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack <= req & ~ack;
      if (avs_read & ~ack)
        avs_readdata <= rd_mux;
    end
  end

  // control, status and send configuration
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_en <= `SFD_CTRL_RST;
      err_st <= 1'b0;
      err_cnt <= '0;
      tx_kind <= 8'h00;
      tx_flags <= 8'h00;
      tx_otq <= 16'h0000;
      tx_valid <= 1'b0;
      tx_hdr <= 32'h0000_0000;
      tx_ext <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_en <= avs_writedata[0];
      // set wins over the write-one clear
      if (flg_err)
        err_st <= 1'b1;
      else if (wr_stat & avs_writedata[`SFD_ST_ERR])
        err_st <= 1'b0;
      if (flg_err)
        err_cnt <= err_cnt + 1'b1;
      if (wr_txcfg)
      begin
        tx_kind <= avs_writedata[7:0];
        tx_flags <= avs_writedata[15:8];
        tx_otq <= avs_writedata[31:16];
      end
      tx_valid <= wr_txgo;
      if (wr_txgo)
      begin
        tx_hdr <= enc_hdr;
        tx_ext <= enc_ext;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  bad_flag_err_a: assert property (fire && st == S_FLG && kind == `SFD_K_DATA
    && rx_data[2] && rx_data[3] |=> err_pulse && err_st) else $error("bad flags not flagged");
  no_bad_pay_a: assert property (pl_valid |-> !bad_r)
    else $error("payload forwarded for invalid flags");
  extra_zero_a: assert property (tx_valid |-> tx_ext[31:16] == 16'h0000)
    else $error("extra flags not zero");
  tx_unused_a: assert property (tx_valid && tx_hdr[31:24] == `SFD_K_HB
    |-> (tx_hdr[23:16] & ~`SFD_M_HB) == 8'h00) else $error("unused flag sent");
  hb_reply_a: assert property (hb_done && !flags[1] |=> hb_reply)
    else $error("reply request missing");
  hb_live_a: assert property (hb_reply || hb_live |-> $past(kind) == `SFD_K_HB
    && $past(st) == S_BODY) else $error("heartbeat event from wrong kind");
  skip_end_a: assert property (fire && st == S_SKIP && skip == 16'h0001 && !sm_end
    |=> st == S_PAY) else $error("skip did not end at payload");
  otq_load_a: assert property (fire && st == S_OTQ1 && !sm_end && j16 > 16'h0001
    |=> st == S_SKIP ##1 skip == $past(j16, 2) - 16'h0001 || !$past(fire))
    else $error("inline qos offset misloaded");
  bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  hb_seen_c: cover property (hb_reply ##[1:40] hb_live);
  err_seen_c: cover property (err_pulse);
  pay_seen_c: cover property (pl_valid [*3]);
  tx_seen_c: cover property (tx_valid);
endmodule
`default_nettype wire

// >>> sim/sfd_peer.sv
// model of the remote participant that sends submessage octets
`timescale 1ns/1ps
`default_nettype none
module sfd_peer
(
  // clock
  input wire logic ref_clk,
  // octet stream toward the decoder
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic rx_ready
);
  // ---------------------------------------------------------------
  // idle line at time zero
  // ---------------------------------------------------------------
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
  end

  // ---------------------------------------------------------------
  // one message, one octet per clock; bad keeps a data-plus-key header
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] m[$], input logic bad);
    logic [7:0] b;
    for (int i = 0; i < m.size(); i++)
    begin
      @(posedge ref_clk);
      b = m[i];
      // a well-behaved sender never sets data and key together
      if (i == 1 && m[0] == 8'h15 && !bad && b[3:2] == 2'b11)
        b[3] = 1'b0;
      rx_valid <= 1'b1;
      rx_data <= b;
      rx_last <= (i == m.size() - 1);
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    // released line shows no stale octet
    rx_data <= ~m[m.size() - 1];
  endtask
endmodule
`default_nettype wire

// >>> sim/sfd_top_test.sv
// self-checking bench of the submessage flag decoder
`timescale 1ns/1ps
`default_nettype none
`include "sfd_cfg.svh"
module sfd_top_test;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, hb_count, tx_hdr, tx_ext, rd;
  logic rx_valid, rx_last, rx_ready, pl_valid, pl_key, pl_k;
  logic err_pulse, hb_reply, hb_live, tx_valid;
  logic [7:0] rx_data, pl_data, pl_d;
  logic [31:0] hdr_q, ext_q;
  int num_errors, total_checks, pl_n, err_n, rep_n, live_n, tx_n;
  logic [7:0] m[$];
  // lookup tables for register, endian-only kind and send cases
  logic [4:0] ra[5] = '{5'h00, 5'h04, 5'h08, 5'h14, 5'h18};
  logic [31:0] rv[5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0] gk[3] = '{8'h08, 8'h0e, 8'h13};
  logic [7:0] tk[4] = '{8'h15, 8'h16, 8'h07, 8'h08};
  logic [7:0] tf[4] = '{8'hfe, 8'hf4, 8'hff, 8'hff};
  logic [31:0] th[4] = '{32'h15160034, 32'h16040034, 32'h07073400, 32'h08013400};
  logic [31:0] te[4] = '{32'h00000012, 32'h00000012, 32'h00001200, 32'h00001200};

  // ---------------------------------------------------------------
  // design, partner and clock
  // ---------------------------------------------------------------
  sfd_top #(.ERR_W(16)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .pl_valid(pl_valid), .pl_data(pl_data),
    .pl_key(pl_key), .err_pulse(err_pulse), .hb_reply(hb_reply), .hb_live(hb_live),
    .hb_count(hb_count), .tx_valid(tx_valid), .tx_hdr(tx_hdr), .tx_ext(tx_ext));
  sfd_peer peer (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready));
  // 200 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // monitor: counts one-cycle pulses and keeps their data
  // ---------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (pl_valid === 1'b1)
    begin
      pl_n++;
      pl_d = pl_data;
      pl_k = pl_key;
    end
    if (err_pulse === 1'b1)
      err_n++;
    if (hb_reply === 1'b1)
      rep_n++;
    if (hb_live === 1'b1)
      live_n++;
    if (tx_valid === 1'b1)
    begin
      tx_n++;
      hdr_q = tx_hdr;
      ext_q = tx_ext;
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // clear event counters away from the clock edge
  task automatic clr();
    @(negedge ref_clk);
    pl_n = 0;
    err_n = 0;
    rep_n = 0;
    live_n = 0;
    tx_n = 0;
  endtask
  // one avalon-mm transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      num_errors++;
      stop_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // send message m and check payload and error pulses
  task automatic rxc(input logic bad, input int npl, input int nerr, input logic [7:0] d,
                     input logic k);
    clr();
    peer.send(m, bad);
    repeat (3) @(posedge ref_clk);
    chk(pl_n, npl);
    chk(err_n, nerr);
    if (npl > 0)
    begin
      chk(pl_d, d);
      chk(pl_k, k);
    end
  endtask
  // heartbeat with count 0x11223344 in the byte order of flag bit 0
  task automatic hb(input logic [7:0] fl, input int rep, input int live);
    // length 28 and count octets, each in the byte order of flag bit 0
    if (fl[0])
      m = {8'h07, fl, 8'h1c, 8'h00};
    else
      m = {8'h07, fl, 8'h00, 8'h1c};
    for (int i = 0; i < 24; i++)
      m.push_back(8'(i));
    if (fl[0])
      m = {m, 8'h44, 8'h33, 8'h22, 8'h11};
    else
      m = {m, 8'h11, 8'h22, 8'h33, 8'h44};
    rxc(1'b0, 0, 0, 8'h00, 1'b0);
    chk(rep_n, rep);
    chk(live_n, live);
    if (rep + live > 0)
      chk(hb_count, 32'h11223344);
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog against a hang
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // reset values, unmapped address reads zero
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    // data, big endian, no inline qos
    m = {8'h15, 8'h04, 8'h00, 8'h06, 8'hab, 8'hcd, 8'h00, 8'h00, 8'h5a, 8'ha5};
    rxc(1'b0, 2, 0, 8'ha5, 1'b0);
    // little endian, inline qos, nonzero extra flags, two octets skipped
    m = {8'h15, 8'h07, 8'h09, 8'h00, 8'hff, 8'hff, 8'h02, 8'h00, 8'h11, 8'h22, 8'h33};
    m = {m, 8'h44, 8'hc3};
    rxc(1'b0, 3, 0, 8'hc3, 1'b0);
    // key payload with non-standard flag, no inline qos but one octet skipped
    m = {8'h15, 8'h18, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01, 8'h99, 8'h77};
    rxc(1'b0, 1, 0, 8'h77, 1'b1);
    // invalid data plus key
    m = {8'h15, 8'h0d, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h77};
    rxc(1'b1, 0, 1, 8'h00, 1'b0);
    bus(1'b0, `SFD_A_STAT, 32'h0);
    chk({rd[16], rd[7:0]}, 32'h115);
    bus(1'b0, `SFD_A_ERRS, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, `SFD_A_STAT, 32'h00010000);
    bus(1'b0, `SFD_A_STAT, 32'h0);
    chk(rd[16], 1'b0);
    // fragments: key, non-standard, inline qos
    m = {8'h16, 8'h04, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h66};
    rxc(1'b0, 1, 0, 8'h66, 1'b1);
    m = {8'h16, 8'h08, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55};
    rxc(1'b0, 1, 0, 8'h55, 1'b0);
    m = {8'h16, 8'h02, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01, 8'h99, 8'h88};
    rxc(1'b0, 1, 0, 8'h88, 1'b0);
    // heartbeats: reply, liveliness, unused bits set, final
    hb(8'h01, 1, 0);
    hb(8'h06, 0, 1);
    hb(8'hf9, 1, 0);
    hb(8'h03, 0, 0);
    bus(1'b0, `SFD_A_HBCNT, 32'h0);
    chk(rd, 32'h11223344);
    // kinds with endian flag only, all other flags set
    for (int i = 0; i < 3; i++)
    begin
      m = {gk[i], 8'hfe, 8'h00, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04};
      rxc(1'b0, 0, 0, 8'h00, 1'b0);
      chk(rep_n + live_n, 0);
      bus(1'b0, `SFD_A_STAT, 32'h0);
      chk(rd[7:0], gk[i]);
    end
    // receive disabled drops octets
    bus(1'b1, `SFD_A_CTRL, 32'h0);
    hb(8'h01, 0, 0);
    bus(1'b1, `SFD_A_CTRL, 32'h1);
    hb(8'h01, 1, 0);
    // send headers: unused flags cleaned, extra flags zero, byte order
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, `SFD_A_TXCFG, {16'h0012, tf[i], tk[i]});
      clr();
      bus(1'b1, `SFD_A_TXGO, 32'h00000034);
      repeat (2) @(posedge ref_clk);
      chk(tx_n, 1);
      chk(hdr_q, th[i]);
      chk(ext_q, te[i]);
    end
    stop_test();
  end
endmodule
`default_nettype wire
